// ===== spiwp_params.svh
// Purpose: Shared constants of the serial EEPROM write-protection block.
// Assumes: Included by bare name from the design files.
// Notes:   Offsets, field positions, opcodes and timing counts live here.
`ifndef SPIWP_PARAMS_SVH
`define SPIWP_PARAMS_SVH

// Opcodes, shifted in most significant bit first.
`define SPIWP_OP_LATCH_SET   8'h06
`define SPIWP_OP_LATCH_CLEAR 8'h04
`define SPIWP_OP_STATUS_WR   8'h01
`define SPIWP_OP_ARRAY_WR    8'h02

// Serial clock counts that complete frames and fields, and the count at which the bit count saturates.
`define SPIWP_BITS_LATCH     10'h008
`define SPIWP_BITS_STATUS    10'h010
`define SPIWP_BITS_ADDR      10'h018
`define SPIWP_BITS_WR_MIN    10'h020
`define SPIWP_BITS_MAX       10'h3FF

// Status byte field positions.
`define SPIWP_SR_PPE         7
`define SPIWP_SR_BP_HI       3
`define SPIWP_SR_BP_LO       2
`define SPIWP_SR_WEL         1
`define SPIWP_SR_BUSY        0

// Lower bounds of the protected array ranges.
`define SPIWP_PROT_QUARTER   13'h1800
`define SPIWP_PROT_HALF      13'h1000

// Reset value of the nonvolatile bits after a factory erase.
`define SPIWP_NV_INIT        3'h0

// Internal write cycle time and master clock period.
`define SPIWP_T_WR_NS        5000000
`define SPIWP_CLK_NS         25

`endif

// ===== spiwp_pkg.sv
// Purpose: Types shared by the write-protection block.
// Assumes: Constants come from spiwp_params.svh.
// Notes:   Frame summary crosses from the serial clock to the master clock.
package spiwp_pkg;

  // Summary of one chip-select frame, built on the serial clock.
  typedef struct packed {
    logic [9:0]  bits;
    logic [7:0]  opcode;
    logic [15:0] addr;
    logic [7:0]  sdata;
  } spiwp_frame_t;

  // Nonvolatile status bits.
  typedef struct packed {
    logic       protect_pin_enable;
    logic       block_protect_hi;
    logic       block_protect_lo;
  } spiwp_nv_t;

  typedef enum logic [1:0] {
    SPIWP_STANDBY,
    SPIWP_ACTIVE,
    SPIWP_WRITING
  } spiwp_state_t;

endpackage : spiwp_pkg

// ===== spiwp_nv_cell.sv
// Purpose: Storage model for nonvolatile status bits.
// Assumes: i_nv_init_n is a factory erase, never the power-on reset.
// Notes:   Contents survive i_resetn, as the real cells survive power loss.
`timescale 1ns/1ps
module spiwp_nv_cell #(
  parameter int         W    = 3,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         i_mclk,
  input  wire logic         i_nv_init_n,
  input  wire logic         i_we,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] cell_ff;
  logic [W-1:0] nxt_cell;

  // Load only on a committed write; otherwise hold.
  always_comb begin
    nxt_cell = i_we ? i_d : cell_ff;
  end

  // Power-on reset is not connected here so the bits persist.
  always_ff @(posedge i_mclk or negedge i_nv_init_n) begin
    if (!i_nv_init_n) begin
      cell_ff <= INIT;
    end else begin
      cell_ff <= nxt_cell;
    end
  end

  assign o_q = cell_ff;

endmodule : spiwp_nv_cell

// ===== spiwp_protect.sv
// Purpose: Write-protection and data-protection logic of a serial EEPROM.
// Assumes: SPI mode 0, data sampled on rising i_sclk; sclk idle with CS high.
// Notes:   Frame decisions are taken on the master clock at CS rise.
`timescale 1ns/1ps
`include "spiwp_params.svh"
module spiwp_protect #(
  parameter int unsigned WR_CYCLES = `SPIWP_T_WR_NS / `SPIWP_CLK_NS
) (
  input  wire logic        i_mclk,
  input  wire logic        i_resetn,
  input  wire logic        i_nv_init_n,
  input  wire logic        i_sclk,
  input  wire logic        i_cs_n,
  input  wire logic        i_si,
  input  wire logic        i_wp_n,
  output logic      [7:0]  o_status,
  output logic             o_busy,
  output logic             o_active,
  output logic             o_hw_protect,
  output logic             o_so_oe,
  output logic             o_wr_start,
  output logic      [12:0] o_wr_addr
);

  // Serial clock domain: frame collection.
  logic                     fresh_ff;
  logic [23:0]              sh_ff;
  logic [23:0]              nxt_sh;
  spiwp_pkg::spiwp_frame_t  frame_ff;
  spiwp_pkg::spiwp_frame_t  nxt_frame;

  // Master clock domain: synchronisers and control.
  logic                     cs_s1_ff;
  logic                     cs_s2_ff;
  logic                     cs_d3_ff;
  logic                     wp_s1_ff;
  logic                     wp_s2_ff;
  logic [1:0]               fill_ff;
  logic                     armed_ff;
  logic                     cs_rise;
  logic                     cs_fall;
  spiwp_pkg::spiwp_state_t  state_ff;
  spiwp_pkg::spiwp_state_t  nxt_state;
  logic                     wel_ff;
  logic                     nxt_wel;
  logic [17:0]              timer_ff;
  logic [17:0]              nxt_timer;
  logic                     pend_sr_ff;
  logic                     nxt_pend_sr;
  spiwp_pkg::spiwp_nv_t     sr_new_ff;
  spiwp_pkg::spiwp_nv_t     nxt_sr_new;
  logic                     wr_start_ff;
  logic                     nxt_wr_start;
  logic [12:0]              wr_addr_ff;
  logic [12:0]              nxt_wr_addr;
  logic                     busy_ff;
  logic                     active_ff;
  logic                     hw_ff;
  logic [7:0]               status_ff;
  logic                     so_oe_ff;
  logic                     nv_we;
  logic                     hw_now;
  logic                     addr_hit;
  logic                     wr_len_ok;
  spiwp_pkg::spiwp_nv_t     nv_q;

  // Protected range lookup for a start address.
  function automatic logic addr_prot(input logic [12:0] a,
                                     input logic [1:0]  bp);
    logic hit;
    hit = 1'b0;
    unique case (bp)
      2'h0: hit = 1'b0;
      2'h1: hit = (a >= `SPIWP_PROT_QUARTER);
      2'h2: hit = (a >= `SPIWP_PROT_HALF);
      2'h3: hit = 1'b1;
    endcase
    return hit;
  endfunction : addr_prot

  // Preset while CS is high so the next frame restarts its count.
  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      fresh_ff <= 1'b1;
    end else begin
      fresh_ff <= 1'b0;
    end
  end

  // Shift and count bits; capture opcode, status byte and address.
  always_comb begin
    nxt_frame = frame_ff;
    if (fresh_ff) begin
      nxt_sh         = {23'h000000, i_si};
      nxt_frame.bits = 10'h001;
    end else begin
      nxt_sh         = {sh_ff[22:0], i_si};
      nxt_frame.bits = (frame_ff.bits == `SPIWP_BITS_MAX) ?
                       frame_ff.bits : frame_ff.bits + 10'h001;
    end
    if (nxt_frame.bits == `SPIWP_BITS_LATCH) begin
      nxt_frame.opcode = nxt_sh[7:0];
    end
    if (nxt_frame.bits == `SPIWP_BITS_STATUS) begin
      nxt_frame.sdata = nxt_sh[7:0];
    end
    if (nxt_frame.bits == `SPIWP_BITS_ADDR) begin
      nxt_frame.addr = nxt_sh[15:0];
    end
  end

  // Serial clock registers; they hold still once the clock stops.
  always_ff @(posedge i_sclk or negedge i_resetn) begin
    if (!i_resetn) begin
      sh_ff    <= 24'h000000;
      frame_ff <= '0;
    end else begin
      sh_ff    <= nxt_sh;
      frame_ff <= nxt_frame;
    end
  end

  // Pin synchronisers; CS resets high so power-up looks deselected.
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      cs_s1_ff <= 1'b1;
      cs_s2_ff <= 1'b1;
      cs_d3_ff <= 1'b1;
      wp_s1_ff <= 1'b1;
      wp_s2_ff <= 1'b1;
      fill_ff  <= 2'h0;
      armed_ff <= 1'b0;
    end else begin
      cs_s1_ff <= i_cs_n;
      cs_s2_ff <= cs_s1_ff;
      cs_d3_ff <= cs_s2_ff;
      wp_s1_ff <= i_wp_n;
      wp_s2_ff <= wp_s1_ff;
      fill_ff  <= {fill_ff[0], 1'b1};
      armed_ff <= armed_ff | (fill_ff[1] & cs_s2_ff);
    end
  end

  // A CS held low through reset never counts as a falling edge.
  assign cs_fall = armed_ff & cs_d3_ff & ~cs_s2_ff;
  // The frame summary is stable here: CS high stopped the serial clock.
  assign cs_rise = ~cs_d3_ff & cs_s2_ff;

  assign hw_now    = nv_q.protect_pin_enable & ~wp_s2_ff;
  assign addr_hit  = addr_prot(frame_ff.addr[12:0],
                               {nv_q.block_protect_hi,
                                nv_q.block_protect_lo});
  // Only whole data bytes after the address make a valid write frame.
  assign wr_len_ok = (frame_ff.bits >= `SPIWP_BITS_WR_MIN) &&
                     (frame_ff.bits[2:0] == 3'h0);
  assign nv_we     = (state_ff == spiwp_pkg::SPIWP_WRITING) &&
                     (timer_ff == 18'h00001) && pend_sr_ff;

  // Frame decode and write cycle control.
  always_comb begin
    nxt_state    = state_ff;
    nxt_wel      = wel_ff;
    nxt_timer    = timer_ff;
    nxt_pend_sr  = pend_sr_ff;
    nxt_sr_new   = sr_new_ff;
    nxt_wr_start = 1'b0;
    nxt_wr_addr  = wr_addr_ff;
    unique case (state_ff)
      spiwp_pkg::SPIWP_STANDBY: begin
        if (cs_fall) begin
          nxt_state = spiwp_pkg::SPIWP_ACTIVE;
        end
      end
      spiwp_pkg::SPIWP_ACTIVE: begin
        if (cs_rise) begin
          nxt_state = spiwp_pkg::SPIWP_STANDBY;
          if (frame_ff.bits == `SPIWP_BITS_LATCH &&
              frame_ff.opcode == `SPIWP_OP_LATCH_SET) begin
            nxt_wel = 1'b1;
          end
          if (frame_ff.bits == `SPIWP_BITS_LATCH &&
              frame_ff.opcode == `SPIWP_OP_LATCH_CLEAR) begin
            nxt_wel = 1'b0;
          end
          // Status write needs the latch and no hardware protection.
          if (frame_ff.bits == `SPIWP_BITS_STATUS &&
              frame_ff.opcode == `SPIWP_OP_STATUS_WR &&
              wel_ff && !hw_now) begin
            nxt_state  = spiwp_pkg::SPIWP_WRITING;
            nxt_timer  = 18'(WR_CYCLES);
            nxt_pend_sr = 1'b1;
            nxt_sr_new = {frame_ff.sdata[`SPIWP_SR_PPE],
                          frame_ff.sdata[`SPIWP_SR_BP_HI],
                          frame_ff.sdata[`SPIWP_SR_BP_LO]};
          end
          // Array write: latch set and start address outside protection.
          if (frame_ff.opcode == `SPIWP_OP_ARRAY_WR && wr_len_ok &&
              wel_ff && !addr_hit) begin
            nxt_state    = spiwp_pkg::SPIWP_WRITING;
            nxt_timer    = 18'(WR_CYCLES);
            nxt_wr_start = 1'b1;
            nxt_wr_addr  = frame_ff.addr[12:0];
          end
        end
      end
      spiwp_pkg::SPIWP_WRITING: begin
        // Frames seen now are dropped; the cycle runs to its end.
        if (timer_ff == 18'h00001) begin
          nxt_state   = spiwp_pkg::SPIWP_STANDBY;
          nxt_wel     = 1'b0;
          nxt_pend_sr = 1'b0;
        end else begin
          nxt_timer = timer_ff - 18'h00001;
        end
      end
    endcase
  end

  // Control registers; the latch clears on power-up.
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_ff    <= spiwp_pkg::SPIWP_STANDBY;
      wel_ff      <= 1'b0;
      timer_ff    <= 18'h00000;
      pend_sr_ff  <= 1'b0;
      sr_new_ff   <= '0;
      wr_start_ff <= 1'b0;
      wr_addr_ff  <= 13'h0000;
      busy_ff     <= 1'b0;
      active_ff   <= 1'b0;
      hw_ff       <= 1'b0;
      status_ff   <= 8'h00;
      so_oe_ff    <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      wel_ff      <= nxt_wel;
      timer_ff    <= nxt_timer;
      pend_sr_ff  <= nxt_pend_sr;
      sr_new_ff   <= nxt_sr_new;
      wr_start_ff <= nxt_wr_start;
      wr_addr_ff  <= nxt_wr_addr;
      busy_ff     <= (nxt_state == spiwp_pkg::SPIWP_WRITING);
      active_ff   <= (nxt_state == spiwp_pkg::SPIWP_ACTIVE);
      hw_ff       <= hw_now;
      status_ff   <= {nv_q.protect_pin_enable, 3'h0,
                      nv_q.block_protect_hi, nv_q.block_protect_lo,
                      wel_ff, busy_ff};
      so_oe_ff    <= 1'b0;
    end
  end

  // Nonvolatile bits commit only when the status write cycle finishes.
  spiwp_nv_cell #(
    .W    (3),
    .INIT (`SPIWP_NV_INIT)
  ) u_nv (
    .i_mclk      (i_mclk),
    .i_nv_init_n (i_nv_init_n),
    .i_we        (nv_we),
    .i_d         (sr_new_ff),
    .o_q         (nv_q)
  );

  assign o_status     = status_ff;
  assign o_busy       = busy_ff;
  assign o_active     = active_ff;
  assign o_hw_protect = hw_ff;
  assign o_so_oe      = so_oe_ff;
  assign o_wr_start   = wr_start_ff;
  assign o_wr_addr    = wr_addr_ff;

  // Checks on the master clock domain.
  default clocking cb_m @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  a_wel_needed: assert property (
    wr_start_ff |-> $past(wel_ff))
    else $error("array write started with latch clear");
  a_block_prot: assert property (
    wr_start_ff |-> !addr_prot(wr_addr_ff, {nv_q.block_protect_hi,
                                            nv_q.block_protect_lo}))
    else $error("write started inside protected range");
  a_wel_done: assert property (
    $fell(busy_ff) |-> !wel_ff)
    else $error("latch still set after write cycle");
  a_busy_ignore: assert property (
    busy_ff && $past(busy_ff) |-> !wr_start_ff && $stable(wr_addr_ff))
    else $error("new write taken during write cycle");
  a_sr_guard: assert property (
    $rose(pend_sr_ff) |-> !$past(hw_now) && $past(wel_ff))
    else $error("status write taken while protected");
  a_hw_active: assert property (
    nv_q.protect_pin_enable && !wp_s2_ff |=> hw_ff)
    else $error("hardware protection not active");
  a_hw_off: assert property (
    !nv_q.protect_pin_enable || wp_s2_ff |=> !hw_ff)
    else $error("hardware protection wrongly active");
  a_status_map: assert property (
    status_ff[6:4] == 3'h0 && status_ff[1] == $past(wel_ff) &&
    status_ff[0] == $past(busy_ff))
    else $error("status byte layout wrong");
  a_active_fall: assert property (
    $rose(active_ff) |-> $past(cs_fall))
    else $error("active state without CS falling edge");
  a_latch_clear: assert property (
    state_ff == spiwp_pkg::SPIWP_ACTIVE && cs_rise &&
    frame_ff.bits == `SPIWP_BITS_LATCH &&
    frame_ff.opcode == `SPIWP_OP_LATCH_CLEAR |=> !wel_ff)
    else $error("latch clear command had no effect");

  c_array_write: cover property (wr_start_ff);
  c_status_commit: cover property (nv_we);
  c_latch_set: cover property ($rose(wel_ff));

endmodule : spiwp_protect

// ===== spiwp_host.sv
// Purpose: Behavioural SPI host that drives frames into the protect block.
// Assumes: Mode 0: clock idles low, data changes while the clock is low.
// Notes:   The serial clock only runs inside frames, at a 125 ns period.
`timescale 1ns/1ps
module spiwp_host (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_si
);
  // Idle bus: deselected, clock stopped.
  // CS rises in the NBA region, so the frame restart flop sees the edge.
  initial begin
    o_sclk = 1'b0;
    o_cs_n <= 1'b1;
    o_si   = 1'b0;
  end

  // Sends the top n bits of v; the gap keeps CS high long enough to sync.
  task automatic xfer(input logic [39:0] v, input int n);
    int i;
    #13;
    o_cs_n = 1'b0;
    for (i = 0; i < n; i++) begin
      o_si = v[39-i];
      #62.5 o_sclk = 1'b1;
      #62.5 o_sclk = 1'b0;
    end
    #31 o_cs_n = 1'b1;
    // The line is driven to the inverse of the last bit, so it no longer shows that bit.
    o_si = ~o_si;
    #500;
  endtask : xfer
endmodule : spiwp_host

// ===== tb_top.sv
// Purpose: Self-checking bench for the write-protection block.
// Assumes: A short write cycle count stands in for the real write time.
// Notes:   A queue-free integer model predicts every frame's outcome.
`timescale 1ns/1ps
module tb_top;
  localparam int WRC = 240;
  logic        i_mclk = 1'b0;
  logic        i_resetn;
  logic        i_nv_init_n;
  logic        act_q = 1'b0;
  logic        i_wp_n = 1'b1;
  logic        sclk, cs_n, si;
  logic [7:0]  o_status;
  logic        o_busy, o_active, o_hw_protect, o_so_oe, o_wr_start;
  logic [12:0] o_wr_addr, eaddr = 13'h0000;
  logic [31:0] rs = 32'h00003194;
  logic [15:0] alist [6] = '{16'h0000, 16'h0FFF, 16'h1000,
                             16'h17FF, 16'h1800, 16'h1FFF};
  int          err_count = 0, tests_run = 0, cyc = 0, starts = 0;
  int          write_enable_latch = 0, bp = 0, ppe = 0, mbusy = 0, pend = 0;
  int          pdat = 0, nstart = 0, k, j, op, acts = 0, nact = 0;

  spiwp_host host (.o_sclk(sclk), .o_cs_n(cs_n), .o_si(si));

  spiwp_protect #(.WR_CYCLES(WRC)) dut (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_nv_init_n(i_nv_init_n),
    .i_sclk(sclk), .i_cs_n(cs_n), .i_si(si), .i_wp_n(i_wp_n),
    .o_status(o_status), .o_busy(o_busy), .o_active(o_active),
    .o_hw_protect(o_hw_protect), .o_so_oe(o_so_oe),
    .o_wr_start(o_wr_start), .o_wr_addr(o_wr_addr));

  // Master clock, 25 ns period.
  always #12.5 i_mclk = ~i_mclk;

  // Counts start pulses and activations and cuts a hang short.
  // Sampling on the falling edge keeps clear of the launching edge.
  always @(negedge i_mclk) begin
    cyc++;
    if (o_wr_start === 1'b1) starts++;
    if (o_active === 1'b1 && act_q !== 1'b1) acts++;
    act_q = o_active;
    if (cyc == 90000) begin
      err_count++;
      finish_test();
    end
  end

  function logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : xs

  function automatic logic prot(input logic [12:0] a);
    case (bp)
      0: return 1'b0;
      1: return a >= 13'h1800;
      2: return a >= 13'h1000;
      default: return 1'b1;
    endcase
  endfunction : prot

  task automatic chk_bit(input string n, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %b seen %b", n, e, g);
    end
  endtask : chk_bit

  task automatic chk_vec(input string n, input logic [15:0] e,
                         input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk_vec

  // Pin changes land on a clock edge and get time to pass the synchroniser.
  task automatic setwp(input logic v);
    @(posedge i_mclk);
    i_wp_n <= v;
    repeat (4) @(posedge i_mclk);
  endtask : setwp

  // Predicts the frame, sends it, then checks the busy level.
  task automatic send(input int o, input int n, input int a, input int d);
    logic [39:0] v;
    int          hp;
    v = {o[7:0], a[15:0], d[7:0], 8'h00};
    if (o == 1) v = {8'h01, d[7:0], 24'h000000};
    hp = ppe && !i_wp_n;
    if (!mbusy) begin
      nact++;
      if (n == 8 && o == 6) write_enable_latch = 1;
      else if (n == 8 && o == 4) write_enable_latch = 0;
      else if (o == 1 && n == 16 && write_enable_latch && !hp) begin
        mbusy = 1;
        pend = 1;
        pdat = d;
      end else if (o == 2 && n >= 32 && n % 8 == 0 && write_enable_latch
                   && !prot(a[12:0])) begin
        mbusy = 1;
        pend = 2;
        nstart++;
        eaddr = a[12:0];
      end
    end
    host.xfer(v, n);
    repeat (8) @(negedge i_mclk);
    chk_bit("busy", mbusy[0], o_busy);
    chk_bit("status_busy", mbusy[0], o_status[0]);
    chk_bit("status_wel", write_enable_latch[0], o_status[1]);
  endtask : send

  // Lets any write cycle finish, commits the model, compares the outputs.
  task automatic settle();
    repeat (WRC + 20) @(negedge i_mclk);
    if (pend == 1) begin
      ppe = pdat[7];
      bp = pdat[3:2];
    end
    if (pend != 0) write_enable_latch = 0;
    pend = 0;
    mbusy = 0;
    chk_vec("status", {8'h00, ppe[0], 3'h0, bp[1:0], write_enable_latch[0], 1'b0},
            {8'h00, o_status});
    chk_bit("hw_protect", ppe[0] & ~i_wp_n, o_hw_protect);
    chk_bit("so_oe", 1'b0, o_so_oe);
    chk_vec("starts", nstart[15:0], starts[15:0]);
    chk_vec("wr_addr", {3'h0, eaddr}, {3'h0, o_wr_addr});
    chk_vec("activations", nact[15:0], acts[15:0]);
  endtask : settle

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  // Main sequence; reset falls in the NBA region so every flop sees it.
  initial begin
    i_resetn <= 1'b0;
    i_nv_init_n <= 1'b0;
    repeat (10) @(posedge i_mclk);
    i_resetn <= 1'b1;
    i_nv_init_n <= 1'b1;
    repeat (6) @(negedge i_mclk);
    chk_bit("active", 1'b0, o_active);
    settle();
    send(8'h02, 32, 16'h0000, 8'h55);
    settle();
    send(8'h06, 8, 0, 0);
    settle();
    send(8'h04, 8, 0, 0);
    settle();
    send(8'h06, 8, 0, 0);
    send(8'h01, 17, 0, 8'h0C);
    send(8'h02, 33, 16'h0000, 8'h11);
    settle();
    for (k = 0; k < 4; k++) begin
      send(8'h06, 8, 0, 0);
      send(8'h01, 16, 0, k << 2);
      settle();
      for (j = 0; j < 6; j++) begin
        send(8'h06, 8, 0, 0);
        send(8'h02, 32, alist[j], xs());
        settle();
      end
    end
    send(8'h06, 8, 0, 0);
    send(8'h01, 16, 0, 8'h80);
    settle();
    for (k = 0; k < 2; k++) begin
      setwp(k[0]);
      send(8'h06, 8, 0, 0);
      send(8'h01, 16, 0, 8'h84);
      settle();
      send(8'h06, 8, 0, 0);
      send(8'h02, 40, 16'h0100, xs());
      settle();
    end
    send(8'h06, 8, 0, 0);
    send(8'h01, 16, 0, 8'h00);
    send(8'h02, 32, 16'h0020, 8'hA5);
    settle();
    for (k = 0; k < 24; k++) begin
      setwp(xs() % 2 == 1);
      op = (xs() % 4 == 0) ? 4 : 6;
      send(op, 8, 0, 0);
      j = xs();
      if (j[0]) send(8'h01, 16, 0, j[15:8] & 8'h8C);
      else send(8'h02, 32, j[31:16], j[15:8]);
      settle();
    end
    finish_test();
  end
endmodule : tb_top
